// [cbtl_regs.svh]
// Purpose: Offsets, field positions and reset values for the control byte lookup block.
// Assumes: APB with 32-bit data, word aligned registers.
// Notes: Control byte field layout is fixed here.
`ifndef CBTL_REGS_SVH
`define CBTL_REGS_SVH
`define CBTL_OFF_CTRL 12'h000
`define CBTL_OFF_SEL 12'h004
`define CBTL_OFF_RX_BASE 12'h008
`define CBTL_OFF_TX_BASE 12'h00C
`define CBTL_OFF_PROTO 12'h010
`define CBTL_OFF_RX_MODE 12'h014
`define CBTL_OFF_TX_MODE 12'h018
`define CBTL_OFF_RIC 12'h01C
`define CBTL_OFF_RX_BCC 12'h020
`define CBTL_OFF_TX_BCC 12'h024
`define CBTL_OFF_STATUS 12'h028
`define CBTL_OFF_SPECIAL 12'h02C
`define CBTL_CTRL_RESTART 0
`define CBTL_MODE_LSB 8
`define CBTL_CB_MODE_LSB 0
`define CBTL_CB_INT 3
`define CBTL_CB_STORE 4
`define CBTL_CB_ACC 5
`define CBTL_CB_BCC 6
`define CBTL_CB_ESC 7
`define CBTL_ZERO32 32'h0000_0000
`define CBTL_ZERO16 16'h0000
`endif

// [cbtl_pkg.sv]
// Purpose: Types for the control byte lookup block.
// Assumes: Eight bit characters and a 3-bit mode.
// Notes: Control byte bits are positioned as in the regs header.
package cbtl_pkg;
   typedef struct packed {
      logic [3:0] line;
      logic [7:0] data;
   } cbtl_char_type;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } cbtl_bus_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_APPLY = 3'b010,
      ST_HOLD = 3'b011,
      ST_STORE = 3'b100
   } cbtl_state_type;
endpackage : cbtl_pkg

// [cbtl_top.sv]
// Purpose: Per-character control byte fetch and disposition for a 16-line multiplexer.
// Assumes: One clock; fetch master and data outputs handshake with valid and ack.
// Notes: Receive characters take priority over transmit characters.
`timescale 1ns/10ps
`include "cbtl_regs.svh"
module cbtl_top
   import cbtl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_rx_valid,
   input wire cbtl_char_type i_rx_char,
   output logic o_rx_ready,
   input wire logic i_tx_valid,
   input wire cbtl_char_type i_tx_char,
   output logic o_tx_ready,
   output logic o_fetch_req,
   output logic [15:0] o_fetch_addr,
   input wire logic i_fetch_ack,
   input wire logic [7:0] i_fetch_data,
   output logic o_store_valid,
   output cbtl_char_type o_store_char,
   output logic o_store_bcc,
   input wire logic i_store_ack,
   output logic o_tx_out_valid,
   output cbtl_char_type o_tx_out_char,
   input wire logic i_tx_out_ack,
   output logic o_tx_send_bcc,
   output logic o_rx_interrupt
);
   logic [15:0] rx_base_reg [16];
   logic [15:0] tx_base_reg [16];
   logic [7:0] esc_reg [16];
   logic [2:0] rx_mode_reg [16];
   logic [2:0] tx_mode_reg [16];
   logic [15:0] rx_bcc_reg [16];
   logic [15:0] tx_bcc_reg [16];
   logic expect_reg [16];
   cbtl_state_type state_reg, state_next;
   cbtl_char_type cur_reg, cur_next;
   logic is_rx_reg, is_rx_next;
   logic [7:0] cb_reg, cb_next;
   logic [3:0] sel_reg;
   logic [7:0] rx_interrupt_char_reg;
   logic [7:0] special_reg;
   logic special_valid_reg;
   logic restart_pulse;
   logic esc_pending_reg, esc_pending_next;
   logic bcc_flag_reg, bcc_flag_next;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic wr_acc;

   function automatic logic [15:0] cb_addr(input logic [15:0] base, input logic [7:0] ch, input logic [2:0] mode);
      logic [15:0] sum;
      sum = base + {8'h00, ch};
      cb_addr = sum + {5'h00, mode, 8'h00};
   endfunction : cb_addr

   function automatic logic [15:0] bcc_add(input logic [15:0] acc, input logic [7:0] ch);
      bcc_add = acc ^ {8'h00, ch};
   endfunction : bcc_add

   // Writes land at the edge where the master sees ready high.
   assign wr_acc = i_psel && i_penable && i_pwrite && pready_reg;
   assign restart_pulse = wr_acc && (i_paddr == `CBTL_OFF_CTRL) && i_pwdata[`CBTL_CTRL_RESTART];

   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      is_rx_next = is_rx_reg;
      cb_next = cb_reg;
      esc_pending_next = esc_pending_reg;
      bcc_flag_next = bcc_flag_reg;
      case (state_reg)
         ST_IDLE: begin
            if (i_rx_valid) begin
               cur_next = i_rx_char;
               is_rx_next = 1'b1;
               state_next = ST_FETCH;
            end else if (i_tx_valid) begin
               cur_next = i_tx_char;
               is_rx_next = 1'b0;
               state_next = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (i_fetch_ack) begin
               cb_next = i_fetch_data;
               state_next = ST_APPLY;
            end
         end
         ST_APPLY: begin
            if (is_rx_reg && cb_reg[`CBTL_CB_INT]) begin
               state_next = ST_HOLD;
            end else begin
               esc_pending_next = !is_rx_reg && cb_reg[`CBTL_CB_ESC];
               bcc_flag_next = cb_reg[`CBTL_CB_BCC];
               state_next = ST_STORE;
            end
         end
         ST_HOLD: begin
            if (restart_pulse) begin
               if (special_valid_reg) begin
                  cb_next = special_reg & ~(8'h01 << `CBTL_CB_INT);
               end else begin
                  cb_next = cb_reg & ~(8'h01 << `CBTL_CB_INT);
               end
               state_next = ST_APPLY;
            end
         end
         ST_STORE: begin
            if (is_rx_reg) begin
               if (!cb_reg[`CBTL_CB_STORE] || i_store_ack) begin
                  state_next = ST_IDLE;
               end
            end else if (i_tx_out_ack) begin
               if (esc_pending_reg) begin
                  esc_pending_next = 1'b0;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         state_reg <= ST_IDLE;
         cur_reg <= '0;
         is_rx_reg <= 1'b0;
         cb_reg <= 8'h00;
         esc_pending_reg <= 1'b0;
         bcc_flag_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         is_rx_reg <= is_rx_next;
         cb_reg <= cb_next;
         esc_pending_reg <= esc_pending_next;
         bcc_flag_reg <= bcc_flag_next;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         for (int i = 0; i < 16; i++) begin
            rx_base_reg[i] <= `CBTL_ZERO16;
            tx_base_reg[i] <= `CBTL_ZERO16;
            esc_reg[i] <= 8'h00;
            rx_mode_reg[i] <= 3'h0;
            tx_mode_reg[i] <= 3'h0;
            rx_bcc_reg[i] <= `CBTL_ZERO16;
            tx_bcc_reg[i] <= `CBTL_ZERO16;
            expect_reg[i] <= 1'b0;
         end
         sel_reg <= 4'h0;
         rx_interrupt_char_reg <= 8'h00;
         special_reg <= 8'h00;
         special_valid_reg <= 1'b0;
         pready_reg <= 1'b0;
         o_prdata <= `CBTL_ZERO32;
         o_rx_interrupt <= 1'b0;
      end else begin
         pready_reg <= i_psel && i_penable && !pready_reg;
         o_prdata <= prdata_next;
         if (wr_acc) begin
            case (i_paddr)
               `CBTL_OFF_SEL: sel_reg <= i_pwdata[3:0];
               `CBTL_OFF_RX_BASE: rx_base_reg[sel_reg] <= i_pwdata[15:0];
               `CBTL_OFF_TX_BASE: tx_base_reg[sel_reg] <= i_pwdata[15:0];
               `CBTL_OFF_PROTO: esc_reg[sel_reg] <= i_pwdata[7:0];
               `CBTL_OFF_SPECIAL: begin
                  special_reg <= i_pwdata[7:0];
                  special_valid_reg <= 1'b1;
               end
               default: begin
               end
            endcase
         end
         if (state_reg == ST_APPLY && is_rx_reg && cb_reg[`CBTL_CB_INT]) begin
            rx_interrupt_char_reg <= cur_reg.data;
            o_rx_interrupt <= 1'b1;
         end else if (state_reg == ST_HOLD && restart_pulse) begin
            o_rx_interrupt <= 1'b0;
            special_valid_reg <= 1'b0;
         end
         if (state_reg == ST_APPLY && !(is_rx_reg && cb_reg[`CBTL_CB_INT])) begin
            if (is_rx_reg) begin
               rx_mode_reg[cur_reg.line] <= cb_reg[2:0];
               expect_reg[cur_reg.line] <= cb_reg[`CBTL_CB_BCC];
               if (cb_reg[`CBTL_CB_ACC] && !expect_reg[cur_reg.line]) begin
                  rx_bcc_reg[cur_reg.line] <= bcc_add(rx_bcc_reg[cur_reg.line], cur_reg.data);
               end
            end else begin
               tx_mode_reg[cur_reg.line] <= cb_reg[2:0];
               if (cb_reg[`CBTL_CB_ACC]) begin
                  tx_bcc_reg[cur_reg.line] <= bcc_add(tx_bcc_reg[cur_reg.line], cur_reg.data);
               end
            end
         end
      end
   end

   always_comb begin
      prdata_next = `CBTL_ZERO32;
      case (i_paddr)
         `CBTL_OFF_SEL: prdata_next = {28'h000_0000, sel_reg};
         `CBTL_OFF_RX_BASE: prdata_next = {16'h0000, rx_base_reg[sel_reg]};
         `CBTL_OFF_TX_BASE: prdata_next = {16'h0000, tx_base_reg[sel_reg]};
         `CBTL_OFF_PROTO: prdata_next = {24'h00_0000, esc_reg[sel_reg]};
         `CBTL_OFF_RX_MODE: prdata_next = {21'h00_0000, rx_mode_reg[sel_reg], 8'h00};
         `CBTL_OFF_TX_MODE: prdata_next = {21'h00_0000, tx_mode_reg[sel_reg], 8'h00};
         `CBTL_OFF_RIC: prdata_next = {24'h00_0000, rx_interrupt_char_reg};
         `CBTL_OFF_RX_BCC: prdata_next = {16'h0000, rx_bcc_reg[sel_reg]};
         `CBTL_OFF_TX_BCC: prdata_next = {16'h0000, tx_bcc_reg[sel_reg]};
         `CBTL_OFF_STATUS: prdata_next = {28'h000_0000, o_rx_interrupt, state_reg};
         `CBTL_OFF_SPECIAL: prdata_next = {24'h00_0000, special_reg};
         default: prdata_next = `CBTL_ZERO32;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_rx_ready <= 1'b0;
         o_tx_ready <= 1'b0;
         o_fetch_req <= 1'b0;
         o_fetch_addr <= `CBTL_ZERO16;
         o_store_valid <= 1'b0;
         o_store_char <= '0;
         o_store_bcc <= 1'b0;
         o_tx_out_valid <= 1'b0;
         o_tx_out_char <= '0;
         o_tx_send_bcc <= 1'b0;
      end else begin
         o_pready <= i_psel && i_penable && !pready_reg;
         o_pslverr <= 1'b0;
         o_rx_ready <= state_reg == ST_IDLE && state_next == ST_FETCH && is_rx_next;
         o_tx_ready <= state_reg == ST_IDLE && state_next == ST_FETCH && !is_rx_next;
         o_fetch_req <= state_next == ST_FETCH;
         if (state_next == ST_FETCH) begin
            o_fetch_addr <= is_rx_next ? cb_addr(rx_base_reg[cur_next.line], cur_next.data, rx_mode_reg[cur_next.line])
                                       : cb_addr(tx_base_reg[cur_next.line], cur_next.data, tx_mode_reg[cur_next.line]);
         end
         o_store_valid <= state_next == ST_STORE && is_rx_reg && cb_next[`CBTL_CB_STORE];
         o_store_char <= cur_reg;
         // The flag is taken before apply rewrites the expectation for the following character.
         if (state_reg == ST_APPLY) begin
            o_store_bcc <= expect_reg[cur_reg.line];
         end
         o_tx_out_valid <= state_next == ST_STORE && !is_rx_reg;
         o_tx_out_char.line <= cur_reg.line;
         o_tx_out_char.data <= esc_pending_next ? esc_reg[cur_reg.line] : cur_reg.data;
         o_tx_send_bcc <= state_reg == ST_STORE && !is_rx_reg && !esc_pending_reg && i_tx_out_ack && bcc_flag_reg;
      end
   end
endmodule : cbtl_top

// [cbtl_top_chk.sv]
// Purpose: Port assertions for the control byte lookup block.
// Assumes: Bound to cbtl_top from the testbench.
// Notes: One clock domain.
`timescale 1ns/10ps
`include "cbtl_regs.svh"
module cbtl_top_chk
   import cbtl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_rx_ready,
   input wire logic o_tx_ready,
   input wire logic o_fetch_req,
   input wire logic [15:0] o_fetch_addr,
   input wire logic i_fetch_ack,
   input wire logic o_store_valid,
   input wire cbtl_char_type o_store_char,
   input wire logic o_store_bcc,
   input wire logic i_store_ack,
   input wire logic o_tx_out_valid,
   input wire cbtl_char_type o_tx_out_char,
   input wire logic i_tx_out_ack,
   input wire logic o_tx_send_bcc,
   input wire logic o_rx_interrupt
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   property p_rx_fetch; o_rx_ready |-> o_fetch_req; endproperty
   a_rx_fetch: assert property (p_rx_fetch) else $error("rx take without fetch");
   property p_tx_fetch; o_tx_ready |-> o_fetch_req; endproperty
   a_tx_fetch: assert property (p_tx_fetch) else $error("tx take without fetch");
   property p_fetch_hold; o_fetch_req && !i_fetch_ack |=> o_fetch_req && $stable(o_fetch_addr); endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped early");
   property p_store_gap; $rose(o_store_valid) |-> !o_fetch_req; endproperty
   a_store_gap: assert property (p_store_gap) else $error("store before fetch end");
   property p_store_hold; o_store_valid && !i_store_ack |=> o_store_valid && $stable(o_store_char); endproperty
   a_store_hold: assert property (p_store_hold) else $error("store not held");
   property p_txo_hold; o_tx_out_valid && !i_tx_out_ack |=> o_tx_out_valid && $stable(o_tx_out_char); endproperty
   a_txo_hold: assert property (p_txo_hold) else $error("tx out not held");
   property p_int_hold;
      o_rx_interrupt && !(i_psel && i_penable && i_pwrite && i_paddr == `CBTL_OFF_CTRL && i_pwdata[0])
      |=> o_rx_interrupt;
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("interrupt lost");
   property p_ready; i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready; endproperty
   a_ready: assert property (p_ready) else $error("bad ready timing");
   property p_bcc_pulse; o_tx_send_bcc |=> !o_tx_send_bcc; endproperty
   a_bcc_pulse: assert property (p_bcc_pulse) else $error("send pulse too long");
   cover property (o_rx_interrupt);
   cover property (o_store_valid && o_store_bcc);
   cover property (o_tx_send_bcc);
endmodule : cbtl_top_chk

// [cbtl_mem_model.sv]
// Purpose: Memory holding the control tables, answering fetches and stores.
// Assumes: Tables written by the bench; missing entries read as zero.
// Notes: Fetch data toggles when not answering.
`timescale 1ns/10ps
module cbtl_mem_model (
   input wire logic i_clock,
   input wire logic i_slow,
   input wire logic i_fetch_req,
   input wire logic [15:0] i_fetch_addr,
   output logic o_fetch_ack,
   output logic [7:0] o_fetch_data,
   input wire logic i_store_valid,
   output logic o_store_ack
);
   logic [7:0] mem [logic [15:0]];
   int wait_cnt = 0;
   initial begin
      o_fetch_ack = 0;
      o_fetch_data = 8'h5a;
      o_store_ack = 0;
   end
   always @(posedge i_clock) begin
      o_fetch_ack <= 0;
      o_fetch_data <= ~o_fetch_data;
      o_store_ack <= i_store_valid && !o_store_ack;
      if (i_fetch_req && !o_fetch_ack) begin
         if (wait_cnt < (i_slow ? 4 : 1)) wait_cnt <= wait_cnt + 1;
         else begin
            wait_cnt <= 0;
            o_fetch_ack <= 1;
            o_fetch_data <= mem.exists(i_fetch_addr) ? mem[i_fetch_addr] : 8'h00;
         end
      end
   end
endmodule : cbtl_mem_model

// [test_cbtl_top.sv]
// Purpose: Self-checking bench for the control byte lookup block.
// Assumes: APB with one wait state; memory model answers fetches.
// Notes: Line 3 is used throughout.
`timescale 1ns/10ps
`include "cbtl_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t %h %h", $time, a, e); end end
module test_cbtl_top
   import cbtl_pkg::*;
;
   logic i_clock = 0, i_rstn = 0, psel = 0, pen = 0, pwr = 0, rxv = 0, txv = 0, txa = 0, slow = 0;
   logic [11:0] padr = 0;
   logic [31:0] pwd = 0, prd, rd;
   logic pready, rxr, txr, freq, fack, sv, sbcc, sack, tov, sendb, irq, sb_last;
   logic [15:0] fadr, fa;
   logic [7:0] fdat;
   cbtl_char_type rxc = 0, txc = 0, sch, toc;
   cbtl_char_type stq[$], toq[$];
   int error_cnt = 0, checked = 0, nb = 0;
   initial forever #5 i_clock = ~i_clock;
   cbtl_top u_dut (.i_clock, .i_rstn, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(), .i_rx_valid(rxv), .i_rx_char(rxc),
      .o_rx_ready(rxr), .i_tx_valid(txv), .i_tx_char(txc), .o_tx_ready(txr), .o_fetch_req(freq),
      .o_fetch_addr(fadr), .i_fetch_ack(fack), .i_fetch_data(fdat), .o_store_valid(sv), .o_store_char(sch),
      .o_store_bcc(sbcc), .i_store_ack(sack), .o_tx_out_valid(tov), .o_tx_out_char(toc),
      .i_tx_out_ack(txa), .o_tx_send_bcc(sendb), .o_rx_interrupt(irq));
   cbtl_mem_model u_mem (.i_clock, .i_slow(slow), .i_fetch_req(freq), .i_fetch_addr(fadr),
      .o_fetch_ack(fack), .o_fetch_data(fdat), .i_store_valid(sv), .o_store_ack(sack));
   always @(posedge i_clock) begin
      txa <= tov & ~txa;
      if (rxr || txr) fa = fadr;
      if (sv && sack) begin
         stq.push_back(sch);
         sb_last = sbcc;
      end
      if (tov && txa) toq.push_back(toc);
      if (sendb) nb++;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge i_clock);
      pen <= 1;
      do @(posedge i_clock); while (pready !== 1'b1);
      rd = prd;
      psel <= 0;
      pen <= 0;
      @(posedge i_clock);
   endtask : apb
   task automatic idle();
      int n;
      n = 0;
      do begin
         apb(0, `CBTL_OFF_STATUS, 0);
         n++;
      end while (rd[2:0] !== 3'b000 && rd[3] !== 1'b1 && n < 50);
   endtask : idle
   task automatic put(input logic tx, input logic [7:0] d);
      if (tx) txv <= 1;
      else rxv <= 1;
      txc <= {4'h3, d};
      rxc <= {4'h3, d};
      do @(posedge i_clock); while ((tx ? txr : rxr) !== 1'b1);
      txv <= 0;
      rxv <= 0;
      @(posedge i_clock);
      idle();
   endtask : put
   task automatic end_of_test();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge i_clock);
      i_rstn <= 1;
      @(posedge i_clock);
      u_mem.mem[16'h4041] = 8'h31;
      u_mem.mem[16'h4003] = 8'h0a;
      u_mem.mem[16'h4017] = 8'h50;
      u_mem.mem[16'h4042] = 8'h10;
      u_mem.mem[16'h6055] = 8'he1;
      apb(1, `CBTL_OFF_SEL, 32'h0000_0003);
      apb(1, `CBTL_OFF_RX_BASE, 32'h0000_4000);
      apb(1, `CBTL_OFF_TX_BASE, 32'h0000_6000);
      apb(1, `CBTL_OFF_PROTO, 32'h0000_0010);
      put(0, 8'h41);
      `CHK(fa, 16'h4041)
      `CHK(stq[0], 12'h341)
      apb(0, `CBTL_OFF_RX_MODE, 0);
      `CHK(rd, 32'h0000_0100)
      put(0, 8'h41);
      `CHK(fa, 16'h4141)
      `CHK(stq.size(), 1)
      apb(0, `CBTL_OFF_RX_BCC, 0);
      `CHK(rd, 32'h0000_0041)
      put(0, 8'h03);
      `CHK(irq, 1'b1)
      apb(0, `CBTL_OFF_RIC, 0);
      `CHK(rd[7:0], 8'h03)
      apb(1, `CBTL_OFF_SPECIAL, 32'h0000_0030);
      apb(1, `CBTL_OFF_CTRL, 32'h0000_0001);
      idle();
      `CHK(irq, 1'b0)
      `CHK(stq.size(), 2)
      apb(0, `CBTL_OFF_RX_MODE, 0);
      `CHK(rd, 32'h0000_0000)
      apb(0, `CBTL_OFF_RX_BCC, 0);
      `CHK(rd, 32'h0000_0042)
      put(0, 8'h17);
      put(0, 8'h42);
      `CHK(sb_last, 1'b1)
      slow <= 1;
      put(1, 8'h55);
      apb(0, `CBTL_OFF_TX_MODE, 0);
      `CHK(fa, 16'h6055)
      `CHK(rd, 32'h0000_0100)
      `CHK(toq[0], 12'h310)
      `CHK(toq[1], 12'h355)
      `CHK(nb, 1)
      apb(0, `CBTL_OFF_TX_BCC, 0);
      `CHK(rd, 32'h0000_0055)
      apb(1, 12'h030, 32'h0000_ffff);
      apb(0, 12'h030, 0);
      `CHK(rd, 32'h0000_0000)
      end_of_test();
   end
endmodule : test_cbtl_top
bind cbtl_top cbtl_top_chk u_chk (.i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
   .o_pready, .o_rx_ready, .o_tx_ready, .o_fetch_req, .o_fetch_addr, .i_fetch_ack, .o_store_valid,
   .o_store_char, .o_store_bcc, .i_store_ack, .o_tx_out_valid, .o_tx_out_char, .i_tx_out_ack,
   .o_tx_send_bcc, .o_rx_interrupt);
